// ===== boot_cmd_top.sv
// serial boot command handler: auto baud, checksum and product info commands
`timescale 1ns/1ps
module boot_cmd_top
  import boot_cmd_pkg::*;
#(
  parameter int          CNT_W     = 16,
  parameter logic [15:0] SUM_FIRST = 16'hc000,
  parameter logic [15:0] SUM_LAST  = 16'hffff,
  parameter logic [7:0]  SIZE_CODE = 8'h11 // arbitrary neutral value
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        RXD,
  output logic             TXD,
  output logic      [15:0] FLASH_ADDR,
  input  wire logic [7:0]  FLASH_DATA,
  output logic             BAUD_LOCKED,
  output logic             HALTED
);

  typedef struct packed {
    boot_state_t      st;
    boot_state_t      ret;
    logic [CNT_W-1:0] meas;
    logic [CNT_W-1:0] low_run;
    logic [CNT_W-1:0] high_run;
    logic [CNT_W-1:0] bitlen;
    logic             baud_ok;
    logic [7:0]       echo;
    logic             rxd_prev;
    logic [1:0]       rx_ph;
    logic [CNT_W-1:0] rx_cnt;
    logic [3:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             rx_done;
    logic             rx_ferr;
    logic             tx_busy;
    logic [CNT_W-1:0] tx_cnt;
    logic [3:0]       tx_bit;
    logic [9:0]       tx_sh;
    logic [4:0]       idx;
    logic [7:0]       sum8;
    logic [15:0]      addr;
    logic [15:0]      sum16;
    logic             erased;
    logic             rd_v;
    logic             fin;
    logic             ovr;
    logic [7:0]       err;
    logic [1:0]       errn;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;

  logic       push_v;
  logic [7:0] push_d;
  logic       push_rdy;
  logic       tx_v;
  logic [7:0] tx_d;
  logic       tx_take;

  logic [CNT_W+3:0] l_ext;
  logic [CNT_W+3:0] h_ext;
  logic [CNT_W+3:0] h_quarter;
  logic             is_first_a;
  logic             is_first_b;
  logic [CNT_W+3:0] tail_len;

  // payload table; index 2..20 is the summed payload
  function automatic logic [7:0] info_byte(input logic [4:0] i);
    case (i)
      5'd0:    info_byte = START_MARK;
      5'd1:    info_byte = INFO_COUNT;
      5'd2:    info_byte = ADDR_LEN;
      5'd3:    info_byte = RSVD_FIRST;
      5'd4:    info_byte = RSVD_ZERO;
      5'd5:    info_byte = RSVD_ZERO;
      5'd6:    info_byte = RSVD_ZERO;
      5'd7:    info_byte = SIZE_CODE;
      5'd8:    info_byte = BLOCK_COUNT;
      5'd9:    info_byte = ROM_FIRST[23:16];
      5'd10:   info_byte = ROM_FIRST[15:8];
      5'd11:   info_byte = ROM_FIRST[7:0];
      5'd12:   info_byte = ROM_LAST[23:16];
      5'd13:   info_byte = ROM_LAST[15:8];
      5'd14:   info_byte = ROM_LAST[7:0];
      5'd15:   info_byte = RAM_FIRST[23:16];
      5'd16:   info_byte = RAM_FIRST[15:8];
      5'd17:   info_byte = RAM_FIRST[7:0];
      5'd18:   info_byte = RAM_LAST[23:16];
      5'd19:   info_byte = RAM_LAST[15:8];
      5'd20:   info_byte = RAM_LAST[7:0];
      default: info_byte = RSVD_ZERO;
    endcase
  endfunction

  resp_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (RESP_DEPTH)
  ) u_resp_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   (push_d),
    .out_valid (tx_v),
    .out_ready (tx_take),
    .out_data  (tx_d)
  );

  assign tx_take = !s_reg.tx_busy;

  // 0x86 gives equal low and high runs, 0x30 a low run 2.5x the high run
  assign l_ext      = (CNT_W+4)'(s_reg.low_run);
  assign h_ext      = (CNT_W+4)'(s_reg.high_run);
  assign h_quarter  = h_ext >> 2;
  assign is_first_a = (l_ext >= h_ext - h_quarter) && (l_ext <= h_ext + h_quarter);
  assign is_first_b = ((l_ext << 1) >= (h_ext << 2)) && ((l_ext << 1) <= (h_ext << 2) + (h_ext << 1));
  // nine and a half bits from the start edge, bit time is half the high run
  assign tail_len   = (h_ext << 2) + h_ext - h_quarter;

  always_comb begin
    s_next         = s_reg;
    s_next.rx_done = 1'b0;
    s_next.rx_ferr = 1'b0;
    s_next.rxd_prev = RXD;
    push_v         = 1'b0;
    push_d         = 8'h00;

    // receiver, runs only once the baud rate is known
    if (s_reg.baud_ok) begin
      case (s_reg.rx_ph)
        2'd0: begin
          if (s_reg.rxd_prev && !RXD) begin
            s_next.rx_ph  = 2'd1;
            s_next.rx_cnt = s_reg.bitlen >> 1;
          end
        end
        2'd1: begin
          if (s_reg.rx_cnt == '0) begin
            s_next.rx_ph  = RXD ? 2'd0 : 2'd2;
            s_next.rx_cnt = s_reg.bitlen - 1'b1;
            s_next.rx_bit = 4'd0;
          end else begin
            s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
          end
        end
        2'd2: begin
          if (s_reg.rx_cnt == '0) begin
            s_next.rx_cnt = s_reg.bitlen - 1'b1;
            if (s_reg.rx_bit == 4'd8) begin
              s_next.rx_ph   = 2'd0;
              s_next.rx_done = 1'b1;
              s_next.rx_ferr = !RXD;
            end else begin
              s_next.rx_sh  = {RXD, s_reg.rx_sh[7:1]};
              s_next.rx_bit = s_reg.rx_bit + 1'b1;
            end
          end else begin
            s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
          end
        end
        default: s_next.rx_ph = 2'd0;
      endcase
    end

    // transmitter, same derived bit time
    if (!s_reg.tx_busy) begin
      if (tx_v) begin
        s_next.tx_busy = 1'b1;
        s_next.tx_sh   = {1'b1, tx_d, 1'b0};
        s_next.tx_cnt  = s_reg.bitlen - 1'b1;
        s_next.tx_bit  = 4'd0;
      end
    end else if (s_reg.tx_cnt == '0) begin
      s_next.tx_cnt = s_reg.bitlen - 1'b1;
      s_next.tx_sh  = {1'b1, s_reg.tx_sh[9:1]};
      s_next.tx_bit = s_reg.tx_bit + 1'b1;
      if (s_reg.tx_bit == 4'd9) begin
        s_next.tx_busy = 1'b0;
      end
    end else begin
      s_next.tx_cnt = s_reg.tx_cnt - 1'b1;
    end

    // a byte arriving mid-reply is reported once the reply is done
    if (s_reg.rx_done && (s_reg.st == S_SUM_RUN || s_reg.st == S_SUM_SEND ||
        s_reg.st == S_INFO || s_reg.st == S_ECHO)) begin
      s_next.ovr = 1'b1;
    end

    case (s_reg.st)
      S_BAUD_WAIT: begin
        if (s_reg.rxd_prev && !RXD) begin
          s_next.st   = S_BAUD_LOW;
          s_next.meas = '0;
        end
      end
      S_BAUD_LOW: begin
        s_next.meas = s_reg.meas + 1'b1;
        if (&s_reg.meas) begin
          s_next.st = S_BAUD_WAIT;
        end else if (RXD) begin
          s_next.st       = S_BAUD_HIGH;
          s_next.low_run  = s_reg.meas;
          s_next.high_run = '0;
        end
      end
      S_BAUD_HIGH: begin
        s_next.meas     = s_reg.meas + 1'b1;
        s_next.high_run = s_reg.high_run + 1'b1;
        if (&s_reg.meas) begin
          s_next.st = S_BAUD_WAIT;
        end else if (!RXD) begin
          s_next.st = S_BAUD_TAIL;
        end
      end
      S_BAUD_TAIL: begin
        s_next.meas = s_reg.meas + 1'b1;
        if (s_reg.high_run < CNT_W'(MIN_HIGH_RUN) || !(is_first_a || is_first_b)) begin
          s_next.st = S_BAUD_WAIT;
        end else if ((CNT_W+4)'(s_reg.meas) >= tail_len && RXD) begin
          s_next.bitlen  = s_reg.high_run >> 1;
          s_next.baud_ok = 1'b1;
          s_next.echo    = is_first_a ? MATCH1_A : MATCH1_B;
          s_next.st      = S_ECHO;
          s_next.ret     = S_MATCH2;
        end else if (&s_reg.meas) begin
          s_next.st = S_BAUD_WAIT;
        end
      end
      S_ECHO: begin
        push_v = 1'b1;
        push_d = s_reg.echo;
        if (push_rdy) begin
          s_next.st  = s_reg.ret;
          s_next.idx = 5'd0;
          s_next.sum8 = 8'h00;
        end
      end
      S_MATCH2: begin
        if (s_reg.rx_done) begin
          if (!s_reg.rx_ferr && (s_reg.rx_sh == MATCH2_A || s_reg.rx_sh == MATCH2_B)) begin
            s_next.echo = s_reg.rx_sh;
            s_next.st   = S_ECHO;
            s_next.ret  = S_CMD;
          end else begin
            // silent refusal, the session must start over with a new first byte
            s_next.baud_ok = 1'b0;
            s_next.st      = S_BAUD_WAIT;
          end
        end
      end
      S_CMD: begin
        s_next.ovr = 1'b0;
        if (s_reg.rx_done) begin
          s_next.errn = 2'd0;
          if (s_reg.rx_ferr) begin
            s_next.err = ERR_FRAME;
            s_next.st  = S_ERR;
          end else if (s_reg.rx_sh == CMD_SUM) begin
            s_next.st     = S_SUM_RUN;
            s_next.addr   = SUM_FIRST;
            s_next.sum16  = 16'h0000;
            s_next.erased = 1'b1;
            s_next.rd_v   = 1'b0;
            s_next.fin    = 1'b0;
          end else if (s_reg.rx_sh == CMD_INFO) begin
            s_next.echo = CMD_INFO;
            s_next.st   = S_ECHO;
            s_next.ret  = S_INFO;
          end else begin
            s_next.err = ERR_COMMAND;
            s_next.st  = S_ERR;
          end
        end
      end
      S_SUM_RUN: begin
        // flash read data lags the address by one cycle
        s_next.rd_v = !s_reg.fin;
        if (s_reg.rd_v) begin
          s_next.sum16 = s_reg.sum16 + {8'h00, FLASH_DATA};
          if (FLASH_DATA != ERASED_BYTE) begin
            s_next.erased = 1'b0;
          end
        end
        if (!s_reg.fin) begin
          if (s_reg.addr == SUM_LAST) begin
            s_next.fin = 1'b1;
          end else begin
            s_next.addr = s_reg.addr + 1'b1;
          end
        end else if (!s_reg.rd_v) begin
          s_next.st  = S_SUM_SEND;
          s_next.idx = 5'd0;
        end
      end
      S_SUM_SEND: begin
        push_v = 1'b1;
        case (s_reg.idx)
          5'd0:    push_d = s_reg.erased ? FLAG_ERASED : FLAG_WRITTEN;
          5'd1:    push_d = s_reg.sum16[15:8];
          default: push_d = s_reg.sum16[7:0];
        endcase
        if (push_rdy) begin
          s_next.idx = s_reg.idx + 1'b1;
          if (s_reg.idx == 5'd2) begin
            s_next.st   = s_reg.ovr ? S_ERR : S_CMD;
            s_next.err  = ERR_OVERRUN;
            s_next.errn = 2'd0;
          end
        end
      end
      S_INFO: begin
        push_v = 1'b1;
        push_d = (s_reg.idx == INFO_LAST_IDX) ? (8'h00 - s_reg.sum8) : info_byte(s_reg.idx);
        if (push_rdy) begin
          s_next.idx = s_reg.idx + 1'b1;
          if (s_reg.idx >= 5'd2) begin
            s_next.sum8 = s_reg.sum8 + push_d;
          end
          if (s_reg.idx == INFO_LAST_IDX) begin
            s_next.st   = s_reg.ovr ? S_ERR : S_CMD;
            s_next.err  = ERR_OVERRUN;
            s_next.errn = 2'd0;
          end
        end
      end
      S_ERR: begin
        push_v = 1'b1;
        push_d = s_reg.err;
        if (push_rdy) begin
          s_next.errn = s_reg.errn + 1'b1;
          if (s_reg.errn == ERR_COPIES - 1'b1) begin
            s_next.st = S_HALT;
          end
        end
      end
      S_HALT: begin
        // only a reset leaves this state
        s_next.st = S_HALT;
      end
      default: s_next.st = S_BAUD_WAIT;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s_reg          <= '0;
      s_reg.rxd_prev <= 1'b1;
      s_reg.tx_sh    <= 10'h3ff;
    end else begin
      s_reg <= s_next;
    end
  end

  // shifter idles at all ones, so the pin comes straight from a flop
  assign TXD         = s_reg.tx_sh[0];
  assign FLASH_ADDR  = s_reg.addr;
  assign BAUD_LOCKED = s_reg.baud_ok;
  assign HALTED      = (s_reg.st == S_HALT);

endmodule // boot_cmd_top

// ===== boot_cmd_pkg.sv
// constants, codes and states for the serial boot command handler
package boot_cmd_pkg;

  localparam logic [7:0] MATCH1_A      = 8'h86;
  localparam logic [7:0] MATCH1_B      = 8'h30;
  localparam logic [7:0] MATCH2_A      = 8'h79;
  localparam logic [7:0] MATCH2_B      = 8'hcf;
  localparam logic [7:0] CMD_SUM       = 8'h90;
  localparam logic [7:0] CMD_INFO      = 8'hc0;
  localparam logic [7:0] ERR_FRAME     = 8'ha1;
  localparam logic [7:0] ERR_OVERRUN   = 8'ha3;
  localparam logic [7:0] ERR_COMMAND   = 8'h63;
  localparam logic [7:0] FLAG_ERASED   = 8'haa;
  localparam logic [7:0] FLAG_WRITTEN  = 8'h55;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam logic [7:0] START_MARK    = 8'h3a;
  localparam logic [7:0] INFO_COUNT    = 8'h13;
  localparam logic [7:0] ADDR_LEN      = 8'h03;
  localparam logic [7:0] RSVD_FIRST    = 8'hfd;
  localparam logic [7:0] RSVD_ZERO     = 8'h00;
  localparam logic [7:0] BLOCK_COUNT   = 8'h01;
  localparam logic [23:0] ROM_FIRST    = 24'h00c000;
  localparam logic [23:0] ROM_LAST     = 24'h00ffff;
  localparam logic [23:0] RAM_FIRST    = 24'h000060;
  localparam logic [23:0] RAM_LAST     = 24'h00083f;
  localparam logic [4:0] INFO_LAST_IDX = 5'h15;
  localparam logic [1:0] ERR_COPIES    = 2'h3;
  localparam int         RESP_DEPTH    = 16;
  localparam int         BYTE_W        = 8;
  localparam int         MIN_HIGH_RUN  = 4;

  typedef enum logic [3:0] {
    S_BAUD_WAIT = 4'h0,
    S_BAUD_LOW  = 4'h1,
    S_BAUD_HIGH = 4'h2,
    S_BAUD_TAIL = 4'h3,
    S_ECHO      = 4'h4,
    S_MATCH2    = 4'h5,
    S_CMD       = 4'h6,
    S_SUM_RUN   = 4'h7,
    S_SUM_SEND  = 4'h8,
    S_INFO      = 4'h9,
    S_ERR       = 4'ha,
    S_HALT      = 4'hb
  } boot_state_t;

endpackage

// ===== resp_fifo.sv
// response byte fifo between command logic and serial transmitter
`timescale 1ns/1ps
module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        do_push;
  logic        do_pop;

  assign in_ready  = (s_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (s_reg.count != '0);
  assign out_data  = s_reg.mem[s_reg.rp];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (do_push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (do_pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
    end
    case ({do_push, do_pop})
      2'b10:   s_next.count = s_reg.count + 1'b1;
      2'b01:   s_next.count = s_reg.count - 1'b1;
      default: s_next.count = s_reg.count;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // resp_fifo

// ===== boot_cmd_monitor.sv
// assertion checker for the serial boot command handler ports
`timescale 1ns/1ps
module boot_cmd_monitor #(
  parameter logic [15:0] SUM_FIRST = 16'hc000,
  parameter logic [15:0] SUM_LAST  = 16'hffff
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        RXD,
  input wire logic        TXD,
  input wire logic [15:0] FLASH_ADDR,
  input wire logic [7:0]  FLASH_DATA,
  input wire logic        BAUD_LOCKED,
  input wire logic        HALTED
);
  // bit time is learnt at run time, so it is pinned to the bench rate here
  localparam int BIT_CYC = 16;
  logic [15:0] low_run_reg;
  logic [7:0]  quiet_reg;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      low_run_reg <= 16'h0000;
      quiet_reg   <= 8'h00;
    end else begin
      low_run_reg <= TXD ? 16'h0000 : low_run_reg + 16'h0001;
      quiet_reg   <= (!HALTED || !TXD) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hff};
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_reset_idle: assert property ($fell(RST) |-> TXD && !BAUD_LOCKED
    && !HALTED && FLASH_ADDR == 16'h0000) else $error("outputs not idle after reset");
  a_silent_unlocked: assert property (!BAUD_LOCKED |-> TXD)
    else $error("serial output active before baud match");
  a_bit_multiple: assert property ($rose(TXD) |-> (low_run_reg % BIT_CYC) == 0)
    else $error("low run on serial output not whole bit times");
  a_scan_step: assert property ($changed(FLASH_ADDR) && $past(FLASH_ADDR) >= SUM_FIRST
    && $past(FLASH_ADDR) < SUM_LAST |-> FLASH_ADDR == $past(FLASH_ADDR) + 16'h0001)
    else $error("flash scan skipped an address");
  a_scan_no_echo: assert property ($changed(FLASH_ADDR) && FLASH_ADDR != 16'h0000
    && FLASH_ADDR <= SUM_LAST |-> TXD) else $error("serial output active during scan");
  a_scan_locked: assert property ($changed(FLASH_ADDR) |-> BAUD_LOCKED)
    else $error("flash scan without baud match");
  a_halt_sticky: assert property (HALTED |=> HALTED)
    else $error("idle state left without reset");
  a_halt_locked: assert property ($rose(HALTED) |-> $past(BAUD_LOCKED))
    else $error("idle state entered outside command phase");
  a_halt_quiet: assert property (quiet_reg == 8'hff |-> TXD)
    else $error("serial output restarted in idle state");
  a_lock_on_stop: assert property ($rose(BAUD_LOCKED) |-> $past(RXD))
    else $error("baud match accepted outside stop bit");
endmodule // boot_cmd_monitor

bind boot_cmd_top boot_cmd_monitor #(.SUM_FIRST(SUM_FIRST), .SUM_LAST(SUM_LAST))
  boot_cmd_monitor_i (.CORE_CLK(CORE_CLK), .RST(RST), .RXD(RXD), .TXD(TXD),
  .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA), .BAUD_LOCKED(BAUD_LOCKED),
  .HALTED(HALTED));

// ===== host_uart.sv
// serial programming controller model: frames out, decodes device frames
`timescale 1ns/1ps
module host_uart #(
  parameter int BIT = 16
) (
  input  wire logic       clk,
  input  wire logic       txd,
  output logic            rxd,
  output logic [8:0]      rx_data,
  output logic            rx_stb
);
  initial begin
    rxd     = 1'b1;
    rx_stb  = 1'b0;
    rx_data = 9'h000;
  end

  // lsb first, stop level chosen by caller so framing faults can be made
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk) rxd = f[i];
      repeat (BIT - 1) @(negedge clk);
    end
    @(negedge clk) rxd = 1'b1;
  endtask

  // samples mid bit; stop level kept in bit 8
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk);
      rx_data[i] = txd;
    end
    rx_stb = 1'b1;
    @(posedge clk);
    rx_stb = 1'b0;
  end
endmodule // host_uart

// ===== boot_cmd_top_tb.sv
// testbench for the serial boot command handler
`timescale 1ns/1ps
module boot_cmd_top_tb;
  import boot_cmd_pkg::*;
  localparam int         BIT = 16;
  localparam logic [7:0] SZ  = 8'h11; // arbitrary size code
  logic        core_clk, rst, rxd, txd, locked, halted, rx_stb;
  logic [15:0] flash_addr;
  logic [7:0]  flash_data;
  logic [7:0]  flash_mem [16];
  logic [8:0]  rx_data;
  logic [8:0]  exp_q [$];
  int          bad_count, n_compared;
  int          seed = 14161;

  boot_cmd_top #(.CNT_W(16), .SUM_FIRST(16'hc000), .SUM_LAST(16'hc00f), .SIZE_CODE(SZ))
    boot_cmd_top_i (.CORE_CLK(core_clk), .RST(rst), .RXD(rxd), .TXD(txd),
    .FLASH_ADDR(flash_addr), .FLASH_DATA(flash_data), .BAUD_LOCKED(locked), .HALTED(halted));
  host_uart #(.BIT(BIT)) host_uart_i (.clk(core_clk), .txd(txd), .rxd(rxd),
    .rx_data(rx_data), .rx_stb(rx_stb));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  logic [3:0]  flash_prev = 4'h0;
  // data of the previous cycle's address, driven off the sampling edge
  always @(negedge core_clk) begin
    flash_data = flash_mem[flash_prev];
    flash_prev = flash_addr[3:0];
  end

  task automatic check(input string what, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a byte with no note against it is a fault, silence is expected then
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) check("unexpected byte", 9'h000, rx_data);
    else check("reply byte", exp_q.pop_front(), rx_data);
  end

  task automatic expect_b(input logic [7:0] b);
    exp_q.push_back({1'b1, b});
  endtask

  task automatic drain(input int gap);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("ERROR replies left expected %0d seen %0d", 0, exp_q.size());
    end
    repeat (gap * BIT) @(negedge core_clk);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic sum_cmd();
    logic [15:0] s;
    logic        erased;
    s = 16'h0000;
    erased = 1'b1;
    for (int i = 0; i < 16; i++) begin
      s = s + {8'h00, flash_mem[i]};
      erased = erased & (flash_mem[i] === 8'hff);
    end
    expect_b(erased ? FLAG_ERASED : FLAG_WRITTEN);
    expect_b(s[15:8]);
    expect_b(s[7:0]);
    host_uart_i.send(CMD_SUM, 1'b1);
    drain(2);
  endtask

  task automatic info_cmd(input logic ovr);
    logic [7:0] p [19];
    logic [7:0] c;
    p = '{ADDR_LEN, RSVD_FIRST, RSVD_ZERO, RSVD_ZERO, RSVD_ZERO, SZ, BLOCK_COUNT,
      ROM_FIRST[23:16], ROM_FIRST[15:8], ROM_FIRST[7:0], ROM_LAST[23:16], ROM_LAST[15:8],
      ROM_LAST[7:0], RAM_FIRST[23:16], RAM_FIRST[15:8], RAM_FIRST[7:0], RAM_LAST[23:16],
      RAM_LAST[15:8], RAM_LAST[7:0]};
    c = 8'h00;
    expect_b(CMD_INFO);
    expect_b(START_MARK);
    expect_b(INFO_COUNT);
    foreach (p[i]) begin
      expect_b(p[i]);
      c = c - p[i];
    end
    expect_b(c);
    if (ovr) repeat (3) expect_b(ERR_OVERRUN);
    host_uart_i.send(CMD_INFO, 1'b1);
    // a second byte lands while the reply is still being built
    if (ovr) host_uart_i.send(CMD_SUM, 1'b1);
    drain(2);
  endtask

  initial begin
    bad_count = 0;
    n_compared = 0;
    rst = 1'b1;
    flash_data = 8'hff;
    for (int i = 0; i < 16; i++) flash_mem[i] = 8'hff;
    do_reset();
    expect_b(MATCH1_A);
    host_uart_i.send(MATCH1_A, 1'b1);
    drain(2);
    expect_b(MATCH2_A);
    host_uart_i.send(MATCH2_A, 1'b1);
    drain(2);
    sum_cmd();
    for (int i = 0; i < 16; i++) flash_mem[i] = 8'($random(seed));
    flash_mem[3] = 8'h12;
    sum_cmd();
    info_cmd(1'b0);
    sum_cmd();
    repeat (3) expect_b(ERR_COMMAND);
    host_uart_i.send(8'h12, 1'b1);
    drain(4);
    check("halted", 9'h001, {8'h00, halted});
    host_uart_i.send(CMD_INFO, 1'b1);
    drain(20);
    // second session: bad first byte, other match pair, refused second byte, framing fault
    do_reset();
    host_uart_i.send(8'h0e, 1'b1);
    drain(4);
    check("locked", 9'h000, {8'h00, locked});
    expect_b(MATCH1_B);
    host_uart_i.send(MATCH1_B, 1'b1);
    drain(2);
    host_uart_i.send(8'h55, 1'b1);
    drain(20);
    check("locked", 9'h000, {8'h00, locked});
    expect_b(MATCH1_B);
    host_uart_i.send(MATCH1_B, 1'b1);
    drain(2);
    expect_b(MATCH2_B);
    host_uart_i.send(MATCH2_B, 1'b1);
    drain(2);
    info_cmd(1'b0);
    repeat (3) expect_b(ERR_FRAME);
    host_uart_i.send(CMD_INFO, 1'b0);
    drain(20);
    // third session: byte received during a reply
    do_reset();
    expect_b(MATCH1_A);
    host_uart_i.send(MATCH1_A, 1'b1);
    drain(2);
    expect_b(MATCH2_A);
    host_uart_i.send(MATCH2_A, 1'b1);
    drain(2);
    info_cmd(1'b1);
    check("halted", 9'h001, {8'h00, halted});
    check("notes left", 9'h000, 9'(exp_q.size()));
    stop_test();
  end

  initial begin
    #1500000;
    bad_count++;
    $display("ERROR watchdog expected done seen timeout");
    stop_test();
  end
endmodule // boot_cmd_top_tb
